/* File: logic/hbp_host.v */
// Host controller driving the flash disk SRAM-like pins from a simple request port.
// Assumes all pin inputs are synchronous to clk_sys_i and the busy pin is pulled up externally.
`timescale 1ns/1ps
`include "hbp_map.vh"
module hbp_host #(
  parameter SETUP_NS = `HBP_SETUP_NS,
  parameter STROBE_NS = `HBP_STROBE_NS,
  parameter HOLD_NS = `HBP_HOLD_NS
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Request port
  input wire req_i,
  input wire req_write_i,
  input wire [`HBP_ADDR_W-1:0] req_addr_i,
  input wire [`HBP_POS_W-1:0] req_pos_i,
  input wire req_wide_i,
  input wire [15:0] req_wdata_i,
  input wire large_variant_i,
  output reg req_ready_o,
  output reg done_o,
  output reg req_error_o,
  output reg [15:0] rdata_o,
  // Straps
  input wire bus_16bit_i,
  output reg bus_16bit_o,
  output reg [`HBP_POS_W-1:0] cascade_position_straps_o,
  // Device pins
  input wire busy_n_i,
  output reg [`HBP_ADDR_W-1:0] addr_o,
  output reg chip_sel_n_o,
  output reg out_strobe_n_o,
  output reg wr_strobe_n_o,
  output reg high_byte_strobe_n_o,
  input wire [15:0] data_i,
  output reg [15:0] data_o,
  output reg data_lo_oe_n_o,
  output reg data_hi_oe_n_o
);
  // Whole cycles, rounded up so a phase never ends short of its time
  localparam integer SETUP_CYC_I = (SETUP_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS;
  localparam integer STROBE_CYC_I = (STROBE_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS;
  localparam integer HOLD_CYC_I = (HOLD_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS;
  localparam [`HBP_CNT_W-1:0] SETUP_CYC = SETUP_CYC_I[`HBP_CNT_W-1:0];
  localparam [`HBP_CNT_W-1:0] STROBE_CYC = STROBE_CYC_I[`HBP_CNT_W-1:0];
  localparam [`HBP_CNT_W-1:0] HOLD_CYC = HOLD_CYC_I[`HBP_CNT_W-1:0];
  localparam integer BYTE_W = `HBP_BYTE_W;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_INIT = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`HBP_CNT_W-1:0] cnt_q;
  reg [`HBP_CNT_W-1:0] cnt_d;
  reg write_q;
  reg wide_q;
  wire pos_ok;
  wire wide_ok;
  wire launch;
  wire req_bad;
  wire req_go;
  wire phase_end;
  wire [`HBP_LANES-1:0] lane_used;
  wire [`HBP_DATA_W-1:0] rd_lane_d;
  genvar g;

  // Position must fit the variant's cascade size
  assign pos_ok = large_variant_i ? (req_pos_i <= `HBP_POS_MAX_LARGE) : (req_pos_i <= `HBP_POS_MAX_SMALL);
  assign wide_ok = ~req_wide_i | bus_16bit_i;
  assign launch = (state_q == ST_IDLE) & req_i & busy_n_i;
  // A refused request causes no pin activity at all, only the error and done pulses
  assign req_bad = launch & ~(pos_ok & wide_ok);
  assign req_go = launch & pos_ok & wide_ok;
  // A count of one or less ends the phase, so a zero setting still lasts one cycle
  assign phase_end = (cnt_q <= `HBP_CNT_LAST);

  // Per byte lane: whether it takes part in the access and what a read captures
  generate
    for (g = 0; g < `HBP_LANES; g = g + 1) begin : g_lane
      if (g == 0) begin : g_low
        assign lane_used[g] = 1'b1;
      end else begin : g_high
        // Upper lanes move only for wide accesses, which the width check allows in 16-bit mode only
        assign lane_used[g] = wide_q;
      end
      // Unused lanes read back as zero rather than whatever floats on the bus
      assign rd_lane_d[g*BYTE_W +: BYTE_W] = lane_used[g] ? data_i[g*BYTE_W +: BYTE_W] : `HBP_BYTE_ZERO;
    end
  endgenerate

  // Phase sequencer: next state and countdown
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_INIT: begin
        // Wait for the device to finish initializing
        if (busy_n_i) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (req_go) begin
          cnt_d = SETUP_CYC;
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (phase_end) begin
          cnt_d = STROBE_CYC;
          state_d = ST_STROBE;
        end else begin
          cnt_d = cnt_q - `HBP_CNT_ONE;
        end
      end
      ST_STROBE: begin
        if (phase_end) begin
          cnt_d = HOLD_CYC;
          state_d = ST_HOLD;
        end else begin
          cnt_d = cnt_q - `HBP_CNT_ONE;
        end
      end
      ST_HOLD: begin
        if (phase_end) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - `HBP_CNT_ONE;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_INIT;
      cnt_q <= `HBP_CNT_ZERO;
      write_q <= 1'b0;
      wide_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (req_go) begin
        write_q <= req_write_i;
        wide_q <= req_wide_i;
      end
    end
  end

  // Request side: ready while idle, one-cycle done and error pulses
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      req_error_o <= 1'b0;
      rdata_o <= `HBP_DATA_RST;
    end else begin
      req_ready_o <= (state_d == ST_IDLE);
      done_o <= req_bad | ((state_q == ST_HOLD) & phase_end);
      req_error_o <= req_bad;
      // Sample at the edge that raises the strobe, while the device still drives
      if ((state_q == ST_STROBE) && phase_end && !write_q) begin
        rdata_o <= rd_lane_d;
      end
    end
  end

  // Device pins: all registered and held steady through each phase
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cascade_position_straps_o <= `HBP_POS_FIRST;
      addr_o <= `HBP_ADDR_RST;
      chip_sel_n_o <= 1'b1;
      out_strobe_n_o <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      high_byte_strobe_n_o <= 1'b1;
      data_o <= `HBP_DATA_RST;
      data_lo_oe_n_o <= 1'b1;
      data_hi_oe_n_o <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_go) begin
            addr_o <= req_addr_i;
            cascade_position_straps_o <= req_pos_i;
            chip_sel_n_o <= 1'b0;
            high_byte_strobe_n_o <= ~req_wide_i;
            data_o <= req_wdata_i;
            data_lo_oe_n_o <= ~req_write_i;
            data_hi_oe_n_o <= ~(req_write_i & req_wide_i);
          end
        end
        ST_SETUP: begin
          if (phase_end) begin
            out_strobe_n_o <= write_q;
            wr_strobe_n_o <= ~write_q;
          end
        end
        ST_STROBE: begin
          if (phase_end) begin
            out_strobe_n_o <= 1'b1;
            wr_strobe_n_o <= 1'b1;
          end
        end
        ST_HOLD: begin
          // Data stays driven through hold so the device latches it cleanly
          if (phase_end) begin
            chip_sel_n_o <= 1'b1;
            high_byte_strobe_n_o <= 1'b1;
            data_lo_oe_n_o <= 1'b1;
            data_hi_oe_n_o <= 1'b1;
          end
        end
        default: begin
          chip_sel_n_o <= 1'b1;
          out_strobe_n_o <= 1'b1;
          wr_strobe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // Width strap follows the board input; only refusals depend on it mid-run
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bus_16bit_o <= 1'b0;
    end else begin
      bus_16bit_o <= bus_16bit_i;
    end
  end
endmodule

/* File: logic/hbp_map.vh */
// Constants for the host-side controller of the SRAM-like flash disk port.
// Assumes a 40 MHz system clock; included by hbp_host.v.
`ifndef HBP_MAP_VH
`define HBP_MAP_VH
`define HBP_ADDR_W 13
`define HBP_POS_W 2
`define HBP_CLK_NS 25
`define HBP_SETUP_NS 50
`define HBP_STROBE_NS 100
`define HBP_HOLD_NS 50
`define HBP_CNT_W 8
`define HBP_POS_MAX_SMALL 2'h3
`define HBP_POS_MAX_LARGE 2'h1
`define HBP_POS_FIRST 2'h0
`define HBP_CNT_ZERO 8'h00
`define HBP_CNT_ONE 8'h01
`define HBP_CNT_LAST 8'h01
`define HBP_ADDR_RST 13'h0000
`define HBP_DATA_RST 16'h0000
`define HBP_DATA_W 16
`define HBP_LANES 2
`define HBP_BYTE_W 8
`define HBP_BYTE_ZERO 8'h00
`endif

/* File: tb/hbp_dev.sv */
// Flash disk port model: one cascade position, busy for a while after reset.
`timescale 1ns/1ps
module hbp_dev #(parameter MY_POS = 2'h0, parameter INIT = 12) (input wire clk_sys_i, rst_i, w16_i,
  input wire cs_n_i, oe_n_i, we_n_i, hbs_n_i, input wire [1:0] pos_i, input wire [12:0] a_i,
  input wire [15:0] d_i, output reg busy_n_o, output wire lo_en_o, hi_en_o, output wire [15:0] q_o);
  reg [15:0] mem [0:8191];
  reg [7:0] cnt_q;
  wire sel = !cs_n_i && pos_i == MY_POS;
  wire hi = w16_i && !hbs_n_i;
  assign lo_en_o = sel && !oe_n_i;
  assign hi_en_o = lo_en_o && hi;
  assign q_o = mem[a_i];
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      busy_n_o <= 1'b0;
    end else if (cnt_q == INIT) busy_n_o <= 1'b1;
    else cnt_q <= cnt_q + 8'h01;
  end
  always @(posedge we_n_i) if (sel) begin
    mem[a_i][7:0] <= d_i[7:0];
    if (hi) mem[a_i][15:8] <= d_i[15:8];
  end
endmodule

/* File: tb/hbp_host_assertions.sv */
// Pin relation checks for hbp_host.
// Bound to every hbp_host; sees only its ports.
`timescale 1ns/1ps
module hbp_chk (input wire clk_sys_i, rst_i, busy_n_i, large_variant_i, done_o, req_error_o, bus_16bit_o,
  input wire [1:0] cascade_position_straps_o,
  input wire chip_sel_n_o, out_strobe_n_o, wr_strobe_n_o, high_byte_strobe_n_o, data_lo_oe_n_o, data_hi_oe_n_o);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  AST_HI_LANE: assert property (!data_hi_oe_n_o |-> !high_byte_strobe_n_o) else $error("hi lane");
  AST_NARROW: assert property (!bus_16bit_o |-> high_byte_strobe_n_o) else $error("narrow hbs");
  AST_CS_GATE: assert property (!(out_strobe_n_o && wr_strobe_n_o) |-> !chip_sel_n_o) else $error("cs");
  AST_RD_BUS: assert property (!out_strobe_n_o |-> data_lo_oe_n_o && wr_strobe_n_o) else $error("rd");
  AST_WR_LEN: assert property ($fell(wr_strobe_n_o) |-> !data_lo_oe_n_o && !wr_strobe_n_o[*4] ##1 wr_strobe_n_o)
    else $error("wr");
  AST_BUSY: assert property ($fell(chip_sel_n_o) |-> $past(busy_n_i)) else $error("busy");
  AST_DONE: assert property ($fell(chip_sel_n_o) |-> ##8 done_o && chip_sel_n_o) else $error("done");
  AST_ERR: assert property (req_error_o |-> done_o && chip_sel_n_o) else $error("err");
  AST_POS: assert property (!chip_sel_n_o |-> cascade_position_straps_o <= (large_variant_i ? 2'h1 : 2'h3))
    else $error("pos");
  cover property ($fell(wr_strobe_n_o));
  cover property ($fell(out_strobe_n_o));
  cover property (req_error_o);
endmodule
bind hbp_host hbp_chk i_hbp_chk (.clk_sys_i, .rst_i, .busy_n_i, .large_variant_i, .done_o, .req_error_o,
  .bus_16bit_o, .cascade_position_straps_o, .chip_sel_n_o, .out_strobe_n_o, .wr_strobe_n_o,
  .high_byte_strobe_n_o, .data_lo_oe_n_o, .data_hi_oe_n_o);

/* File: tb/tb_top.sv */
// Self-checking bench: hbp_host driving the port model.
`timescale 1ns/1ps
module tb_top;
  reg clk_sys_i = 0, rst_i = 1, req_i = 0, req_write_i = 0, req_wide_i = 0, large_variant_i = 0, bus_16bit_i = 1;
  reg [12:0] req_addr_i = 0;
  reg [1:0] req_pos_i = 0;
  reg [15:0] req_wdata_i = 0;
  reg [15:0] sh [0:8191];
  reg [17:0] q [$];
  reg [17:0] n;
  integer seed = 59651, err_total = 0, checks_done = 0, i, r;
  wire ready, done, rerr, w16, cs_n, oe_n, we_n, hbs_n, lo_oe_n, hi_oe_n, busy_n, lo_en, hi_en;
  wire [1:0] pos;
  wire [12:0] a;
  wire [15:0] rd, dq, dm, bus;
  // Released lanes toggle so a stale value never passes for data
  wire [15:0] flt = {16{clk_sys_i}} ^ 16'h5A5A;
  assign bus[7:0] = !lo_oe_n ? dq[7:0] : lo_en ? dm[7:0] : flt[7:0];
  assign bus[15:8] = !hi_oe_n ? dq[15:8] : hi_en ? dm[15:8] : flt[15:8];
  always #12.5 clk_sys_i = ~clk_sys_i;
  hbp_host i_hbp_host (.clk_sys_i, .rst_i, .req_i, .req_write_i, .req_addr_i, .req_pos_i, .req_wide_i,
    .req_wdata_i, .large_variant_i, .req_ready_o(ready), .done_o(done), .req_error_o(rerr), .rdata_o(rd),
    .bus_16bit_i, .bus_16bit_o(w16), .cascade_position_straps_o(pos), .busy_n_i(busy_n), .addr_o(a),
    .chip_sel_n_o(cs_n), .out_strobe_n_o(oe_n), .wr_strobe_n_o(we_n), .high_byte_strobe_n_o(hbs_n),
    .data_i(bus), .data_o(dq), .data_lo_oe_n_o(lo_oe_n), .data_hi_oe_n_o(hi_oe_n));
  hbp_dev #(.MY_POS(2'h0)) i_hbp_dev (.clk_sys_i, .rst_i, .w16_i(w16), .cs_n_i(cs_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .hbs_n_i(hbs_n), .pos_i(pos), .a_i(a), .d_i(bus), .busy_n_o(busy_n), .lo_en_o(lo_en),
    .hi_en_o(hi_en), .q_o(dm));
  task chk_err(input got, input exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_rd(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input wd, input [1:0] p, input [12:0] ad, input [15:0] wv, input e);
    begin
      while (ready !== 1'b1) @(negedge clk_sys_i);
      q.push_back({w, e, wd ? sh[ad] : {8'h00, sh[ad][7:0]}});
      if (w && !e && p == 2'h0) begin
        if (wd) sh[ad] = wv;
        else sh[ad][7:0] = wv[7:0];
      end
      {req_i, req_write_i, req_wide_i, req_pos_i, req_addr_i, req_wdata_i} = {1'b1, w, wd, p, ad, wv};
      @(negedge clk_sys_i);
      req_i = 0;
      @(negedge clk_sys_i);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(negedge clk_sys_i) if (done === 1'b1) begin
    if (q.size() == 0) begin
      err_total = err_total + 1;
      $display("BAD t=%0t got %h exp %h", $time, done, 1'b0);
    end else begin
      n = q.pop_front();
      chk_err(rerr, n[16]);
      if (!n[17] && !n[16]) chk_rd(rd, n[15:0]);
    end
  end
  initial begin
    #200000 err_total = err_total + 1;
    give_verdict;
  end
  initial begin
    repeat (5) @(negedge clk_sys_i);
    rst_i = 0;
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      xfer(1, 1, 2'h0, r[12:0], r[31:16], 0);
      xfer(1, 0, 2'h0, r[12:0], ~r[31:16], 0);
      xfer(0, 1, 2'h0, r[12:0], 16'h0000, 0);
      xfer(0, 0, 2'h0, r[12:0], 16'h0000, 0);
    end
    $display("wide and narrow transfers done");
    bus_16bit_i = 0;
    xfer(1, 0, 2'h0, 13'h1FFF, 16'hBEEF, 0);
    xfer(1, 1, 2'h0, 13'h1FFF, 16'h1234, 1);
    xfer(0, 0, 2'h0, 13'h1FFF, 16'h0000, 0);
    $display("narrow bus done");
    bus_16bit_i = 1;
    xfer(1, 1, 2'h0, 13'h0000, 16'hC3C3, 0);
    large_variant_i = 1;
    xfer(1, 0, 2'h2, 13'h0000, 16'h0000, 1);
    xfer(1, 0, 2'h1, 13'h0000, 16'h00A5, 0);
    large_variant_i = 0;
    xfer(1, 0, 2'h3, 13'h0000, 16'h005A, 0);
    xfer(0, 1, 2'h0, 13'h0000, 16'h0000, 0);
    while (q.size() > 0) @(negedge clk_sys_i);
    $display("cascade positions done");
    give_verdict;
  end
endmodule
